// ==== dv/fetch_path_model.sv ====
`timescale 1ns/1ps
// program memory fetch path: hands queued words to the decoder, one per valid cycle
module fetch_path_model (
  // clock
  input wire logic mclk_i,
  // stall control, high lets the fetch path insert idle cycles
  input wire logic slow_i,
  // fetch port towards the decoder
  output logic fetch_valid_o,
  output logic [23:0] fetch_word_o,
  output logic cond_true_o,
  // no word left to hand out
  output logic empty_o
);
  logic [24:0] pending[$]; // queued {cond, word}
  logic [24:0] item; // word being presented
  logic slow_s; // stall control sampled at the edge

  // idle, nothing presented
  initial begin
    fetch_valid_o = 1'b0;
    fetch_word_o = 24'h000000;
    cond_true_o = 1'b0;
    empty_o = 1'b1;
  end

  // queue one word with its condition result
  function automatic void push(input logic [23:0] w, input logic c);
    pending.push_back({c, w});
    empty_o = 1'b0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // present a word just after the edge, or idle with a changing pattern
  always @(posedge mclk_i) begin
    slow_s = slow_i;
    #2;
    if (pending.size() > 0 && !(slow_s && $urandom_range(2) == 0)) begin
      item = pending.pop_front();
      fetch_valid_o = 1'b1;
      fetch_word_o = item[23:0];
      cond_true_o = item[24];
    end else begin
      // released lines must not look like the last word
      fetch_valid_o = 1'b0;
      fetch_word_o = ~fetch_word_o;
      cond_true_o = ~cond_true_o;
    end
    empty_o = (pending.size() == 0);
  end
endmodule

// ==== dv/test_instr_format_cycle_decoder.sv ====
`timescale 1ns/1ps
// self-checking bench: reference sequencer beside the decoder
module test_instr_format_cycle_decoder;
  import decode_pkg::*;
  logic mclk_i, rst_i, fetch_valid_i, cond_true_i, slow, empty;
  logic [23:0] fetch_word_i;
  logic flush_o, exec_valid_o, write_en_o, nop_cycle_o, program_counter_load_o, ext_fault_o;
  class_t class_o;
  logic [7:0] opcode_o;
  logic [3:0] base_operand_reg_o, source_operand_reg_o, dest_operand_reg_o, bit_select_field_o;
  logic [1:0] src_mode_o, dst_mode_o, table_mode_o;
  logic dst_present_o, file_to_default_working_reg_o, bit_indirect_o, bit_on_file_o;
  logic [12:0] file_addr_o;
  logic [15:0] literal_o, ext_word_o;
  int n_errors, n_tests, cycles;
  // reference model state
  state_t m_st;
  int m_cnt;
  logic [23:0] m_held, s_w;
  logic s_v, s_c, s_r, e_ev, e_we, e_nop, e_pc, e_ft;
  logic [7:0] o, e_opc;
  class_t k, e_cls;
  logic [7:0] ops[22] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
                          8'h0a, 8'h0b, 8'h0f, 8'h10, 8'h1f, 8'h20, 8'h33, 8'h36, 8'h40, 8'h41,
                          8'h55, 8'hf0};

  instr_format_cycle_decoder i_instr_format_cycle_decoder (.mclk_i(mclk_i), .rst_i(rst_i),
    .fetch_valid_i(fetch_valid_i), .fetch_word_i(fetch_word_i), .cond_true_i(cond_true_i),
    .flush_o(flush_o), .exec_valid_o(exec_valid_o), .write_en_o(write_en_o), .nop_cycle_o(nop_cycle_o),
    .program_counter_load_o(program_counter_load_o), .ext_fault_o(ext_fault_o), .class_o(class_o),
    .opcode_o(opcode_o), .base_operand_reg_o(base_operand_reg_o), .source_operand_reg_o(source_operand_reg_o),
    .src_mode_o(src_mode_o), .dest_operand_reg_o(dest_operand_reg_o), .dst_mode_o(dst_mode_o),
    .dst_present_o(dst_present_o), .file_addr_o(file_addr_o), .file_to_default_working_reg_o(file_to_default_working_reg_o),
    .bit_select_field_o(bit_select_field_o), .bit_indirect_o(bit_indirect_o), .bit_on_file_o(bit_on_file_o),
    .literal_o(literal_o), .ext_word_o(ext_word_o), .table_mode_o(table_mode_o));

  fetch_path_model i_fetch_path_model (.mclk_i(mclk_i), .slow_i(slow), .fetch_valid_o(fetch_valid_i),
    .fetch_word_o(fetch_word_i), .cond_true_o(cond_true_i), .empty_o(empty));

  ////////////////////////////////////////////////////////////////////////////
  // clock, 50 ns period
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  // expected class of an opcode
  function automatic class_t cls_of(input logic [7:0] op);
    case (op)
      8'h00: return CL_NOP;
      8'h01, 8'h03: return CL_BRANCH;
      8'h02, 8'h04, 8'h06: return CL_DWORD;
      8'h05: return CL_INDIR;
      8'h07, 8'h08: return CL_RETURN;
      8'h09, 8'h0a: return CL_TABLE;
      default: ;
    endcase
    case (op[7:4])
      4'h0: return CL_CONDBR;
      4'h1: return CL_SKIP;
      4'h2: return CL_FILE;
      4'h3: return CL_BIT;
      4'h4: return CL_LITMOV;
      4'h5: return CL_LITALU;
      default: return CL_DEFAULT_WORKING_REG;
    endcase
  endfunction

  // compare one value, count and report
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // queue an instruction, and a zero-topped second word for pairs
  task automatic put(input logic [7:0] op, input logic c);
    i_fetch_path_model.push({op, 16'($urandom)}, c);
    if (cls_of(op) == CL_DWORD) begin
      i_fetch_path_model.push({8'h00, 16'($urandom)}, 1'b0);
    end
  endtask

  // wait, bounded, until the fetch path has handed everything out
  task automatic drain(input string nm);
    int n;
    n = 0;
    while (!empty && n < 3000) begin
      @(posedge mclk_i);
      n++;
    end
    // a fetch path that never empties counts as a mismatch
    if (!empty) n_errors++;
    repeat (4) @(posedge mclk_i);
    #2;
    $display("test %s done", nm);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // reference sequencer: expected strobes and fields one edge after each take
  always @(posedge mclk_i) begin
    s_v = fetch_valid_i;
    s_w = fetch_word_i;
    s_c = cond_true_i;
    s_r = rst_i;
    #1;
    {e_ev, e_we, e_nop, e_pc, e_ft} = 5'h00;
    o = s_w[23:16];
    if (s_r) begin
      m_st = ST_EXEC;
      chk("class_rst", class_o, CL_NOP);
      chk("opcode_rst", opcode_o, 32'h0);
    end else if (s_v) begin
      case (m_st)
        ST_EXEC: begin
          k = cls_of(o);
          if (k == CL_NOP) begin
            e_nop = 1'b1;
          end else if (k == CL_DWORD) begin
            m_st = ST_WORD2;
            m_held = s_w;
          end else begin
            e_ev = 1'b1;
            e_cls = k;
            e_opc = o;
            e_we = k inside {CL_DEFAULT_WORKING_REG, CL_FILE, CL_BIT, CL_LITMOV, CL_LITALU, CL_TABLE};
            e_pc = k inside {CL_BRANCH, CL_INDIR, CL_RETURN} || (k == CL_CONDBR && s_c);
            m_cnt = (k == CL_RETURN) ? 2 : ((k inside {CL_BRANCH, CL_INDIR, CL_TABLE} || e_pc) ? 1 : 0);
            if (m_cnt != 0) m_st = ST_FILL;
            if (k == CL_SKIP && s_c) m_st = ST_SKIP;
          end
        end
        ST_WORD2: begin
          e_ev = 1'b1;
          e_we = 1'b1;
          e_cls = CL_DWORD;
          e_opc = m_held[23:16];
          e_pc = (m_held[23:16] != OPC_DW_MOVE);
          e_ft = (o != 8'h00);
          chk("ext_word", ext_word_o, s_w[15:0]);
          m_st = ST_EXEC;
        end
        ST_FILL: begin
          e_nop = 1'b1;
          m_cnt--;
          if (m_cnt == 0) m_st = ST_EXEC;
        end
        default: begin
          // skipped word: a pair costs one more dropped fetch
          e_nop = 1'b1;
          m_cnt = 1;
          m_st = (cls_of(o) == CL_DWORD) ? ST_FILL : ST_EXEC;
        end
      endcase
    end
    chk("exec_valid", exec_valid_o, e_ev);
    chk("write_en", write_en_o, e_we);
    chk("nop_cycle", nop_cycle_o, e_nop);
    chk("pc_load", program_counter_load_o, e_pc);
    chk("ext_fault", ext_fault_o, e_ft);
    chk("flush", flush_o, m_st == ST_FILL || m_st == ST_SKIP);
    if (e_ev) begin
      chk("class", class_o, e_cls);
      chk("opcode", opcode_o, e_opc);
      if (e_cls != CL_DWORD) chk("ext_word_zero", ext_word_o, 32'h0);
      case (e_cls)
        CL_DEFAULT_WORKING_REG: chk("default_working_reg_fields", {base_operand_reg_o, dst_mode_o, dest_operand_reg_o, src_mode_o,
                                     source_operand_reg_o}, s_w[15:0]);
        CL_LITALU: chk("lit_fields", {base_operand_reg_o, dest_operand_reg_o, dst_present_o, literal_o[4:0]},
                       {s_w[15:12], s_w[9:6], s_w[5], s_w[4:0]});
        CL_FILE: chk("file_fields", {file_to_default_working_reg_o, file_addr_o}, s_w[13:0]);
        CL_BIT: begin
          // indirect forms take the position from the base register, literal field reads zero
          chk("bit_fields", {bit_indirect_o, bit_on_file_o, bit_select_field_o},
              {o[1] & ~o[0], o[0], (o[1] & ~o[0]) ? 4'h0 : {o[2], s_w[15:13]}});
          chk("bit_base", base_operand_reg_o, (o[1] & ~o[0]) ? s_w[15:12] : 4'h0);
        end
        CL_LITMOV: begin
          // register form: low nibble target, 12-bit literal; file form: address, 3-bit literal
          chk("litmov_lit", literal_o, o[0] ? {13'h0000, s_w[15:13]} : {4'h0, s_w[15:4]});
          chk("litmov_dst", {dst_present_o, dest_operand_reg_o, file_addr_o},
              o[0] ? {5'h00, s_w[12:0]} : {1'b1, s_w[3:0], 13'h0000});
        end
        CL_TABLE: chk("table_mode", table_mode_o, s_w[15:14]);
        CL_BRANCH: chk("address", literal_o, s_w[15:0]);
        default: ;
      endcase
    end
  end

  // hang guard
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles >= 30000) begin
      n_errors++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_i = 1'b1;
    slow = 1'b0;
    n_errors = 0;
    n_tests = 0;
    cycles = 0;
    m_st = ST_EXEC;
    m_cnt = 0;
    void'($urandom(77426));
    repeat (20) @(posedge mclk_i);
    #2;
    rst_i = 1'b0;
    // every class, condition false then true, each followed by two register ops
    foreach (ops[i]) begin
      for (int c = 0; c < 2; c++) begin
        put(ops[i], c[0]);
        put(8'h60, 1'b0);
        put(8'h61, 1'b0);
      end
    end
    drain("class_sweep");
    // taken skip over a pair, over a single, then a lone second word
    put(8'h12, 1'b1);
    put(OPC_DW_CALL, 1'b0);
    put(8'h7e, 1'b0);
    put(8'h13, 1'b1);
    put(8'h2c, 1'b0);
    put(8'h00, 1'b1);
    put(8'h35, 1'b0);
    drain("skips");
    // pair whose second word breaks the zero opcode, then back-to-back pairs while stalling
    slow = 1'b1;
    i_fetch_path_model.push({OPC_DW_MOVE, 16'h1234}, 1'b0);
    i_fetch_path_model.push(24'h5a5678, 1'b0);
    put(OPC_DW_GOTO, 1'b0);
    put(OPC_DW_MOVE, 1'b0);
    put(OPC_DW_CALL, 1'b0);
    drain("pairs");
    // return leaves the sequencer mid-fill, then a reset in mid-run
    put(OPC_RETURN_FROM_INTERRUPT_OP, 1'b0);
    drain("fill_hold");
    rst_i = 1'b1;
    repeat (2) @(posedge mclk_i);
    #2;
    rst_i = 1'b0;
    // random mix with stalls
    for (int n = 0; n < 500; n++) begin
      put(8'($urandom), 1'($urandom));
    end
    drain("random");
    end_sim();
  end
endmodule

// ==== hdl/decode_pkg.sv ====
package decode_pkg;

  //////////////////////////////////////////////////////////////////////
  // word layout
  localparam int WORD_W = 24;
  localparam int OPC_W = 8;
  localparam int OPC_LSB = 16;
  localparam int ARG_W = 16;
  localparam int FILE_W = 13;

  // opcodes with fixed meaning
  localparam logic [7:0] OPC_NOP = 8'h00;
  localparam logic [7:0] OPC_BRANCH_OP = 8'h01;
  localparam logic [7:0] OPC_DW_GOTO = 8'h02;
  localparam logic [7:0] OPC_BRANCH_COMP = 8'h03;
  localparam logic [7:0] OPC_DW_CALL = 8'h04;
  localparam logic [7:0] OPC_INDIRECT = 8'h05;
  localparam logic [7:0] OPC_DW_MOVE = 8'h06;
  localparam logic [7:0] OPC_RETURN = 8'h07;
  localparam logic [7:0] OPC_RETURN_FROM_INTERRUPT_OP = 8'h08;
  localparam logic [7:0] OPC_TABLE_RD = 8'h09;
  localparam logic [7:0] OPC_TABLE_WR = 8'h0a;

  // opcode groups by the upper nibble
  localparam logic [3:0] GRP_CTRL = 4'h0;
  localparam logic [3:0] GRP_SKIP = 4'h1;
  localparam logic [3:0] GRP_FILE = 4'h2;
  localparam logic [3:0] GRP_BIT = 4'h3;
  localparam logic [3:0] GRP_LITMOV = 4'h4;
  localparam logic [3:0] GRP_LITALU = 4'h5;

  // added no-op cycles per class
  localparam logic [1:0] EXTRA_NONE = 2'd0;
  localparam logic [1:0] EXTRA_TAKEN = 2'd1;
  localparam logic [1:0] EXTRA_BRANCH = 2'd1;
  localparam logic [1:0] EXTRA_INDIR = 2'd1;
  localparam logic [1:0] EXTRA_TABLE = 2'd1;
  localparam logic [1:0] EXTRA_RETURN = 2'd2;
  localparam logic [1:0] EXTRA_SKIP_DW = 2'd1;

  // instruction classes
  typedef enum logic [3:0] {
    CL_NOP = 4'h0, CL_DEFAULT_WORKING_REG = 4'h1, CL_FILE = 4'h2, CL_BIT = 4'h3,
    CL_LITMOV = 4'h4, CL_LITALU = 4'h5, CL_BRANCH = 4'h6, CL_INDIR = 4'h7,
    CL_TABLE = 4'h8, CL_RETURN = 4'h9, CL_CONDBR = 4'ha, CL_SKIP = 4'hb,
    CL_DWORD = 4'hc
  } class_t;

  // sequencer states
  typedef enum logic [1:0] {
    ST_EXEC = 2'b00, ST_WORD2 = 2'b01, ST_FILL = 2'b10, ST_SKIP = 2'b11
  } state_t;

  //////////////////////////////////////////////////////////////////////
  // class of an opcode
  function automatic class_t classify(input logic [7:0] opc);
    class_t c;
    c = CL_DEFAULT_WORKING_REG;
    if (opc == OPC_NOP) begin
      c = CL_NOP;
    end else if (opc == OPC_DW_GOTO || opc == OPC_DW_CALL || opc == OPC_DW_MOVE) begin
      c = CL_DWORD;
    end else if (opc == OPC_BRANCH_OP || opc == OPC_BRANCH_COMP) begin
      c = CL_BRANCH;
    end else if (opc == OPC_INDIRECT) begin
      c = CL_INDIR;
    end else if (opc == OPC_RETURN || opc == OPC_RETURN_FROM_INTERRUPT_OP) begin
      c = CL_RETURN;
    end else if (opc == OPC_TABLE_RD || opc == OPC_TABLE_WR) begin
      c = CL_TABLE;
    end else if (opc[7:4] == GRP_CTRL) begin
      c = CL_CONDBR;
    end else if (opc[7:4] == GRP_SKIP) begin
      c = CL_SKIP;
    end else if (opc[7:4] == GRP_FILE) begin
      c = CL_FILE;
    end else if (opc[7:4] == GRP_BIT) begin
      c = CL_BIT;
    end else if (opc[7:4] == GRP_LITMOV) begin
      c = CL_LITMOV;
    end else if (opc[7:4] == GRP_LITALU) begin
      c = CL_LITALU;
    end
    return c;
  endfunction

  // unconditional added no-op cycles of a class
  function automatic logic [1:0] extra_cycles(input class_t c);
    logic [1:0] n;
    n = EXTRA_NONE;
    if (c == CL_BRANCH) n = EXTRA_BRANCH;
    if (c == CL_INDIR) n = EXTRA_INDIR;
    if (c == CL_TABLE) n = EXTRA_TABLE;
    if (c == CL_RETURN) n = EXTRA_RETURN;
    return n;
  endfunction

endpackage

// ==== hdl/fields_if.sv ====
`timescale 1ns/1ps
// operand fields travelling between sequencer and field splitter
interface fields_if;
  import decode_pkg::*;
  logic [23:0] word; // instruction word being decoded
  class_t cls; // its class
  logic [3:0] base_reg;
  logic [3:0] src_reg;
  logic [1:0] src_mode;
  logic [3:0] dst_reg;
  logic [1:0] dst_mode;
  logic dst_present;
  logic [12:0] file_addr;
  logic file_to_default_working_reg;
  logic [3:0] bit_sel;
  logic bit_indirect;
  logic bit_on_file;
  logic [15:0] literal;
  logic [1:0] table_mode;
  // splitter side
  modport splitter(input word, cls, output base_reg, src_reg, src_mode, dst_reg, dst_mode,
                   dst_present, file_addr, file_to_default_working_reg, bit_sel, bit_indirect, bit_on_file,
                   literal, table_mode);
  // sequencer side
  modport sequencer(output word, cls, input base_reg, src_reg, src_mode, dst_reg, dst_mode,
                    dst_present, file_addr, file_to_default_working_reg, bit_sel, bit_indirect, bit_on_file,
                    literal, table_mode);
endinterface

// ==== hdl/instr_format_cycle_decoder.sv ====
`timescale 1ns/1ps
// fetch sequencing, cycle counting and operand decode of program words
module instr_format_cycle_decoder (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // fetch path, one word per instruction cycle
  input wire logic fetch_valid_i,
  input wire logic [23:0] fetch_word_i,
  // condition result of the word on the fetch port
  input wire logic cond_true_i,
  // sequencing
  output logic flush_o,
  output logic exec_valid_o,
  output logic write_en_o,
  output logic nop_cycle_o,
  output logic program_counter_load_o,
  output logic ext_fault_o,
  // decoded instruction
  output decode_pkg::class_t class_o,
  output logic [7:0] opcode_o,
  output logic [3:0] base_operand_reg_o,
  output logic [3:0] source_operand_reg_o,
  output logic [1:0] src_mode_o,
  output logic [3:0] dest_operand_reg_o,
  output logic [1:0] dst_mode_o,
  output logic dst_present_o,
  output logic [12:0] file_addr_o,
  output logic file_to_default_working_reg_o,
  output logic [3:0] bit_select_field_o,
  output logic bit_indirect_o,
  output logic bit_on_file_o,
  output logic [15:0] literal_o,
  output logic [15:0] ext_word_o,
  output logic [1:0] table_mode_o
);
  import decode_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // state
  state_t state_reg; // sequencer state
  state_t state_next;
  logic [1:0] nop_cnt_reg; // no-op cycles still owed
  logic [1:0] nop_cnt_next;
  logic [23:0] word1_reg; // first word of a double-word instruction

  fields_if fld (); // operand splitter link

  //////////////////////////////////////////////////////////////////////
  // decode of the incoming word
  wire take = fetch_valid_i; // an instruction cycle with a fetched word
  wire [7:0] fetch_opc = fetch_word_i[23:16]; // opcode on top 8 bits
  wire class_t fetch_cls = classify(fetch_opc);
  wire fetch_dw = (fetch_cls == CL_DWORD); // one of the three two-word opcodes
  wire in_exec = (state_reg == ST_EXEC);
  wire in_word2 = (state_reg == ST_WORD2);
  wire in_fill = (state_reg == ST_FILL);
  wire in_skip = (state_reg == ST_SKIP);
  // conditional classes whose test came out true
  wire taken_cond = (fetch_cls == CL_CONDBR) && cond_true_i;
  wire taken_skip = (fetch_cls == CL_SKIP) && cond_true_i;
  // a zero opcode alone executes as nothing
  wire lone_second = in_exec && (fetch_cls == CL_NOP);
  // word executes now
  wire exec_now = take && ((in_exec && !fetch_dw && !lone_second) || in_word2);
  // word is discarded as an inserted no-op
  wire discard = in_fill || in_skip;
  // class that the committed instruction carries
  wire class_t exec_cls = in_word2 ? CL_DWORD : fetch_cls;
  // classes that write registers or memory
  wire writes = (exec_cls == CL_DEFAULT_WORKING_REG) || (exec_cls == CL_FILE) || (exec_cls == CL_BIT) ||
                (exec_cls == CL_LITMOV) || (exec_cls == CL_LITALU) || (exec_cls == CL_TABLE) ||
                (exec_cls == CL_DWORD);
  // the program counter is reloaded
  wire jumps = (exec_cls == CL_BRANCH) || (exec_cls == CL_INDIR) || (exec_cls == CL_RETURN) ||
               (exec_cls == CL_DWORD && word1_reg[23:16] != OPC_DW_MOVE) ||
               (in_exec && taken_cond);

  // word handed to the splitter: stored first word while the second arrives
  assign fld.word = in_word2 ? word1_reg : fetch_word_i;
  assign fld.cls = exec_cls;

  // operand field splitter
  operand_split u_split (
    .f(fld)
  );

  //////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    state_next = state_reg;
    nop_cnt_next = nop_cnt_reg;
    if (take) begin
      unique case (state_reg)
        ST_EXEC: begin
          if (fetch_dw) begin
            // hold the first word, wait for the second
            state_next = ST_WORD2;
          end else if (taken_skip) begin
            // drop the next word, maybe its second too
            state_next = ST_SKIP;
          end else if (taken_cond) begin
            // one added no-op after a taken
            state_next = ST_FILL;
            nop_cnt_next = EXTRA_TAKEN;
          end else if (extra_cycles(fetch_cls) != EXTRA_NONE) begin
            // fixed multi-cycle classes
            state_next = ST_FILL;
            nop_cnt_next = extra_cycles(fetch_cls);
          end
        end
        ST_WORD2: begin
          // second word completes the pair in two cycles
          state_next = ST_EXEC;
        end
        ST_FILL: begin
          // count the no-op cycles off
          nop_cnt_next = nop_cnt_reg - 2'd1;
          if (nop_cnt_reg == 2'd1) state_next = ST_EXEC;
        end
        ST_SKIP: begin
          // skipped two-word instruction costs one more cycle
          if (fetch_dw) begin
            state_next = ST_FILL;
            nop_cnt_next = EXTRA_SKIP_DW;
          end else begin
            state_next = ST_EXEC;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // sequencer registers
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_reg <= ST_EXEC;
      nop_cnt_reg <= 2'd0;
    end else begin
      state_reg <= state_next;
      nop_cnt_reg <= nop_cnt_next;
    end
  end

  // first word capture
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      word1_reg <= 24'h000000;
    end else if (take && in_exec && fetch_dw) begin
      word1_reg <= fetch_word_i;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // per-cycle strobes; writes held off on inserted no-ops
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      exec_valid_o <= 1'b0;
      write_en_o <= 1'b0;
      nop_cycle_o <= 1'b0;
      program_counter_load_o <= 1'b0;
      ext_fault_o <= 1'b0;
    end else begin
      exec_valid_o <= exec_now;
      write_en_o <= exec_now && writes;
      nop_cycle_o <= take && (discard || lone_second);
      program_counter_load_o <= exec_now && jumps;
      // second word must hold a zero opcode field
      ext_fault_o <= take && in_word2 && (fetch_opc != OPC_NOP);
    end
  end

  // decoded fields, loaded when an instruction executes
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      class_o <= CL_NOP;
      opcode_o <= 8'h00;
      base_operand_reg_o <= 4'h0;
      source_operand_reg_o <= 4'h0;
      src_mode_o <= 2'b00;
      dest_operand_reg_o <= 4'h0;
      dst_mode_o <= 2'b00;
      dst_present_o <= 1'b0;
      file_addr_o <= 13'h0000;
      file_to_default_working_reg_o <= 1'b0;
      bit_select_field_o <= 4'h0;
      bit_indirect_o <= 1'b0;
      bit_on_file_o <= 1'b0;
      literal_o <= 16'h0000;
      ext_word_o <= 16'h0000;
      table_mode_o <= 2'b00;
    end else if (exec_now) begin
      class_o <= exec_cls;
      opcode_o <= fld.word[23:16];
      base_operand_reg_o <= fld.base_reg;
      source_operand_reg_o <= fld.src_reg;
      src_mode_o <= fld.src_mode;
      dest_operand_reg_o <= fld.dst_reg;
      dst_mode_o <= fld.dst_mode;
      dst_present_o <= fld.dst_present;
      file_addr_o <= fld.file_addr;
      file_to_default_working_reg_o <= fld.file_to_default_working_reg;
      bit_select_field_o <= fld.bit_sel;
      bit_indirect_o <= fld.bit_indirect;
      bit_on_file_o <= fld.bit_on_file;
      literal_o <= fld.literal;
      // operand half of the 48-bit pair
      ext_word_o <= in_word2 ? fetch_word_i[15:0] : 16'h0000;
      table_mode_o <= fld.table_mode;
    end
  end

  // fetched word is thrown away this cycle
  assign flush_o = discard;

  //////////////////////////////////////////////////////////////////////
  // checks
  sequence s_dw_first;
    take && in_exec && fetch_dw;
  endsequence

  sequence s_dw_second;
    take && in_word2;
  endsequence

  property p_lone_second;
    @(posedge mclk_i) disable iff (rst_i)
    (take && in_exec && fetch_opc == OPC_NOP) |=> nop_cycle_o && !write_en_o && !exec_valid_o;
  endproperty
  a_lone_second: assert property (p_lone_second) else $error("lone second word not a no-op");

  property p_dw_holds;
    @(posedge mclk_i) disable iff (rst_i)
    s_dw_first |=> !exec_valid_o && state_reg == ST_WORD2;
  endproperty
  a_dw_holds: assert property (p_dw_holds) else $error("double-word first cycle executed");

  property p_dw_two;
    @(posedge mclk_i) disable iff (rst_i)
    s_dw_first ##1 s_dw_second |=> exec_valid_o && class_o == CL_DWORD && state_reg == ST_EXEC;
  endproperty
  a_dw_two: assert property (p_dw_two) else $error("double-word not done in two cycles");

  property p_single_one;
    @(posedge mclk_i) disable iff (rst_i)
    (take && in_exec && fetch_cls == CL_DEFAULT_WORKING_REG) |=> write_en_o && state_reg == ST_EXEC;
  endproperty
  a_single_one: assert property (p_single_one) else $error("single word not one cycle");

  property p_cond_taken;
    @(posedge mclk_i) disable iff (rst_i)
    (take && in_exec && taken_cond) |=> program_counter_load_o && flush_o && nop_cnt_reg == 2'd1;
  endproperty
  a_cond_taken: assert property (p_cond_taken) else $error("taken test lacks one no-op");

  property p_return_three;
    @(posedge mclk_i) disable iff (rst_i)
    (take && in_exec && fetch_cls == CL_RETURN) |=> in_fill && nop_cnt_reg == EXTRA_RETURN;
  endproperty
  a_return_three: assert property (p_return_three) else $error("return not three cycles");

  property p_skip_dw;
    @(posedge mclk_i) disable iff (rst_i)
    (take && in_skip && fetch_dw) |=> in_fill && nop_cnt_reg == EXTRA_SKIP_DW;
  endproperty
  a_skip_dw: assert property (p_skip_dw) else $error("skip over two words not three cycles");

  property p_flush_quiet;
    @(posedge mclk_i) disable iff (rst_i)
    (take && flush_o) |=> !write_en_o && nop_cycle_o;
  endproperty
  a_flush_quiet: assert property (p_flush_quiet) else $error("write during no-op cycle");

endmodule

// ==== hdl/operand_split.sv ====
`timescale 1ns/1ps
// splits the operand bits of one word by class
module operand_split (
  fields_if.splitter f
);
  import decode_pkg::*;

  wire [7:0] opc = f.word[23:16];
  wire [15:0] arg = f.word[15:0];
  wire reg3 = (f.cls == CL_DEFAULT_WORKING_REG);
  wire lit_alu = (f.cls == CL_LITALU);
  wire lit_mov = (f.cls == CL_LITMOV);
  wire bit_op = (f.cls == CL_BIT);
  wire ctrl = (f.cls == CL_BRANCH) || (f.cls == CL_INDIR) || (f.cls == CL_CONDBR) ||
              (f.cls == CL_SKIP) || (f.cls == CL_DWORD) || (f.cls == CL_TABLE);

  // base register: no modifier, also the indirect bit source
  assign f.base_reg = (reg3 || lit_alu || (bit_op && f.bit_indirect)) ? arg[15:12] : 4'h0;
  // source register with modifier
  assign f.src_reg = (reg3 || (bit_op && !f.bit_on_file)) ? arg[3:0] : 4'h0;
  assign f.src_mode = (reg3 || (bit_op && !f.bit_on_file)) ? arg[5:4] : 2'b00;
  // destination register; literal-move register form uses low nibble
  assign f.dst_reg = (reg3 || lit_alu) ? arg[9:6] : ((lit_mov && !opc[0]) ? arg[3:0] : 4'h0);
  assign f.dst_mode = (reg3 || lit_alu) ? arg[11:10] : 2'b00;
  // separate destination for register ops, literal-move register form, and literal arithmetic when flagged
  assign f.dst_present = reg3 || (lit_alu && arg[5]) || (lit_mov && !opc[0]);
  // file register address spans 0000h to 1fffh
  assign f.file_addr = ((f.cls == CL_FILE) || ((bit_op || lit_mov) && opc[0])) ?
                       arg[12:0] : 13'h0000;
  // destination select: back to file or to working_reg_zero
  assign f.file_to_default_working_reg = (f.cls == CL_FILE) && arg[13];
  // bit forms: file or register operand, literal or indirect position
  assign f.bit_on_file = bit_op && opc[0];
  assign f.bit_indirect = bit_op && opc[1] && !opc[0];
  assign f.bit_sel = (bit_op && !f.bit_indirect) ? {opc[2], arg[15:13]} : 4'h0;
  // literal per class
  assign f.literal = lit_alu ? {11'h000, arg[4:0]} :
                     (lit_mov && !opc[0]) ? {4'h0, arg[15:4]} :
                     lit_mov ? {13'h0000, arg[15:13]} :
                     ctrl ? arg : 16'h0000;
  // table access mode
  assign f.table_mode = (f.cls == CL_TABLE) ? arg[15:14] : 2'b00;
endmodule
